// ### design/pftm_ctrl.sv
// Purpose: Pin float test mode capture and pin float gating
// Assumes: Core drives its pins through this block; pads resolve oe
// Notes: Chip-select inputs are sampled as the synchronised reset input rises
//   Pad floats trail the reset pin by the two-flop synchroniser and the pad register
//
// Contract
// - Float mode holds pins until next reset
// - Enter only with both selects low
// - Weak pull-ups on both select pins
// - Float all pins except crystal output
// - Float address/data bus in hold acknowledge
// - Float address/data bus during reset low
// - Reset input synchronised before edge use
`timescale 1ns/1ps
module pftm_ctrl (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Board pins seen by the block
  input wire logic reset_input_n_i,
  input wire logic upper_memory_select_n_i,
  input wire logic lower_memory_select_n_i,
  // Core state
  input wire logic hold_ack_i,
  // Core-side pin drive
  input wire pftm_pkg::pftm_ad_t core_ad_i,
  input wire pftm_pkg::pftm_misc_t core_misc_i,
  input wire logic core_ucs_n_i,
  input wire logic core_lcs_n_i,
  input wire logic crystal_output_i,
  // Pad-side pin drive
  output pftm_pkg::pftm_ad_t pad_ad_o,
  output pftm_pkg::pftm_misc_t pad_misc_o,
  output logic pad_ucs_n_o,
  output logic pad_ucs_oe_o,
  output logic pad_lcs_n_o,
  output logic pad_lcs_oe_o,
  output logic select_pullup_en_o,
  output logic crystal_output_o,
  // Status
  output logic pin_float_test_mode_o
);
  import pftm_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Reset input synchronisation

  logic reset_sync;
  logic reset_prev_reg;
  logic sel_both_low;
  logic reset_rise;

  // Crosses the asynchronous reset pin into the clock domain
  pftm_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(reset_input_n_i),
    .sync_o(reset_sync)
  );

  // Edge found on the synchronised copy, never on the raw pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reset_prev_reg <= 1'b0;
    end else begin
      reset_prev_reg <= reset_sync;
    end
  end

  assign reset_rise = reset_sync & ~reset_prev_reg;
  // Selects are level inputs; the tester holds them past the edge
  assign sel_both_low = ~upper_memory_select_n_i &
    ~lower_memory_select_n_i;

  ////////////////////////////////////////////////////////////////////////
  // Mode state

  pftm_state_t state_reg;
  pftm_state_t state_next;

  // Reset low always returns to RESET so the mode clears there
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PFTM_ST_RESET: begin
        if (reset_rise) begin
          state_next = sel_both_low ? PFTM_ST_FLOAT : PFTM_ST_RUN;
        end
      end
      PFTM_ST_SAMPLE: begin
        state_next = PFTM_ST_RUN;
      end
      PFTM_ST_RUN: begin
        if (!reset_sync) begin
          state_next = PFTM_ST_RESET;
        end
      end
      PFTM_ST_FLOAT: begin
        // Only a fresh reset ends float mode
        if (!reset_sync) begin
          state_next = PFTM_ST_RESET;
        end
      end
      default: begin
        state_next = PFTM_ST_RESET;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= PFTM_ST_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Float decisions

  logic float_all;
  logic float_ad;

  // Decided from the next state so pads and status switch together
  assign float_all = (state_next == PFTM_ST_FLOAT);
  // Bus floats in hold, in reset and in float mode
  assign float_ad = float_all | hold_ack_i |
    (state_next == PFTM_ST_RESET);

  ////////////////////////////////////////////////////////////////////////
  // Registered pad drive; one cycle latency traded for clean outputs

  pftm_ad_t ad_next;
  pftm_misc_t misc_next;
  logic in_run;
  logic sel_oe_next;

  // Data always passes; only the enables are gated, so a pad that comes
  // back from floating shows current data, never a stale value
  assign ad_next.dout = core_ad_i.dout;
  assign ad_next.oe = float_ad ? '0 : core_ad_i.oe;
  assign misc_next.dout = core_misc_i.dout;
  assign misc_next.oe = float_all ? '0 : core_misc_i.oe;

  // Selects stay released while reset is low so the straps can be read;
  // in run they stay driven through hold, as only the bus floats there
  assign in_run = (state_next == PFTM_ST_RUN);
  assign sel_oe_next = in_run | (~float_all & ~float_ad);

  // Address/data bus pads
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_ad_o <= '0;
    end else begin
      pad_ad_o <= ad_next;
    end
  end

  // Remaining pads
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_misc_o <= '0;
    end else begin
      pad_misc_o <= misc_next;
    end
  end

  // Upper select pad; released in reset, so the pull-up or strap wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_ucs_n_o <= 1'b1;
      pad_ucs_oe_o <= 1'b0;
    end else begin
      pad_ucs_n_o <= core_ucs_n_i;
      pad_ucs_oe_o <= sel_oe_next;
    end
  end

  // Lower select pad, same scheme as the upper one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_lcs_n_o <= 1'b1;
      pad_lcs_oe_o <= 1'b0;
    end else begin
      pad_lcs_n_o <= core_lcs_n_i;
      pad_lcs_oe_o <= sel_oe_next;
    end
  end

  // Mode status moves on the same edge as the pad enables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_float_test_mode_o <= PFTM_MODE_RST;
    end else begin
      pin_float_test_mode_o <= float_all;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Always-on items

  // Pull-ups keep the mode from being picked up by accident
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      select_pullup_en_o <= PFTM_PULLUP_ON;
    end else begin
      select_pullup_en_o <= PFTM_PULLUP_ON;
    end
  end

  // Crystal output keeps driving in every mode
  // The board under test still needs a clock while the pins float
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      crystal_output_o <= 1'b0;
    end else begin
      crystal_output_o <= crystal_output_i;
    end
  end

endmodule

// ### design/pftm_pkg.sv
// Purpose: Shared types and constants for the pin float test mode block
// Assumes: Single 100 MHz clock, synchronous active-high reset
// Notes: Pin groups travel as packed structs of out/oe pairs
package pftm_pkg;

  // Width of the multiplexed address/data bus
  localparam int unsigned PFTM_AD_W = 8;
  // Number of other core-driven pins routed through the float gate
  localparam int unsigned PFTM_MISC_W = 16;
  // Reset input synchroniser depth
  localparam int unsigned PFTM_SYNC_STAGES = 2;
  // Clocks the selects must stay low after the synchronised reset input rises
  localparam int unsigned PFTM_SEL_HOLD_CLKS = 1;
  // Reset values
  localparam logic PFTM_MODE_RST = 1'b0;
  localparam logic [1:0] PFTM_SYNC_RST = 2'h0;
  // Weak pull-up enable: always on in every mode
  localparam logic PFTM_PULLUP_ON = 1'b1;

  // Mode capture state machine
  typedef enum logic [1:0] {
    PFTM_ST_RESET  = 2'b00,
    PFTM_ST_SAMPLE = 2'b01,
    PFTM_ST_RUN    = 2'b10,
    PFTM_ST_FLOAT  = 2'b11
  } pftm_state_t;

  // Output and enable of the address/data bus
  typedef struct packed {
    logic [PFTM_AD_W-1:0] dout;
    logic [PFTM_AD_W-1:0] oe;
  } pftm_ad_t;

  // Output and enable of the remaining pins
  typedef struct packed {
    logic [PFTM_MISC_W-1:0] dout;
    logic [PFTM_MISC_W-1:0] oe;
  } pftm_misc_t;

endpackage

// ### design/pftm_sync.sv
// Purpose: Two-flop synchroniser for the asynchronous reset input
// Assumes: Input may change at any time relative to clk_i
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module pftm_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Asynchronous level in, synchronised level out
  input wire logic async_i,
  output logic sync_o
);
  import pftm_pkg::*;

  logic [1:0] stage_reg;

  // Plain shift chain; stage 0 is never looked at elsewhere
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage_reg <= PFTM_SYNC_RST;
    end else begin
      stage_reg <= {stage_reg[0], async_i};
    end
  end

  assign sync_o = stage_reg[1];

endmodule

// ### tb/pftm_checker.sv
// Purpose: Port assertions for the pin float test mode block
// Assumes: One clock, synchronous active-high reset
// Notes: Bus checks allow for the registered pad stage
`timescale 1ns/1ps
module pftm_checker (
  // Clock, reset, board pins and core hold acknowledge
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic reset_input_n_i,
  input wire logic upper_memory_select_n_i,
  input wire logic lower_memory_select_n_i,
  input wire logic hold_ack_i,
  // Pad side
  input wire pftm_pkg::pftm_ad_t pad_ad_o,
  input wire pftm_pkg::pftm_misc_t pad_misc_o,
  input wire logic pad_ucs_oe_o,
  input wire logic pad_lcs_oe_o,
  input wire logic select_pullup_en_o,
  input wire logic pin_float_test_mode_o
);
  import pftm_pkg::*;
  ////////////////////////////////////////////////////////////////////
  // Short aliases keep all properties but p_fpin on one line
  wire md = pin_float_test_mode_o;
  wire sel_low = !upper_memory_select_n_i && !lower_memory_select_n_i;
  wire ad_off = pad_ad_o.oe == 8'h00;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_pu; select_pullup_en_o; endproperty
  a_pu: assert property (p_pu) else $error("pullup dropped");
  property p_fad; md |-> ad_off; endproperty
  a_fad: assert property (p_fad) else $error("bus driven");
  property p_fpin; md |-> !pad_ucs_oe_o && !pad_lcs_oe_o
    && pad_misc_o.oe == 16'h0000; endproperty
  a_fpin: assert property (p_fpin) else $error("pin driven");
  property p_hold; hold_ack_i ##1 hold_ack_i |-> ad_off; endproperty
  a_hold: assert property (p_hold) else $error("bus in hold");
  property p_rlow; !reset_input_n_i [*4] |-> ad_off; endproperty
  a_rlow: assert property (p_rlow) else $error("bus in reset");
  property p_keep; reset_input_n_i [*4] ##0 md |=> md; endproperty
  a_keep: assert property (p_keep) else $error("mode lost");
  property p_ent; $rose(md) |-> $past(sel_low); endproperty
  a_ent: assert property (p_ent) else $error("bad entry");
  property p_sync; $rose(md) |-> $past(reset_input_n_i, 2); endproperty
  a_sync: assert property (p_sync) else $error("early entry");
  c_ent: cover property ($rose(md));
  c_hold: cover property (hold_ack_i ##1 hold_ack_i);
  c_exit: cover property ($fell(md));
endmodule
bind pftm_ctrl pftm_checker u_chk (.clk_i, .rst_i, .reset_input_n_i,
  .upper_memory_select_n_i, .lower_memory_select_n_i, .hold_ack_i,
  .pad_ad_o, .pad_misc_o, .pad_ucs_oe_o, .pad_lcs_oe_o,
  .select_pullup_en_o, .pin_float_test_mode_o);

// ### tb/pftm_strap.sv
// Purpose: Board straps on the two select pins
// Assumes: Strap ties a pin low; otherwise the weak pull-up wins
// Notes: With no pull-up and no driver the pin floats to z
`timescale 1ns/1ps
module pftm_strap (
  // Strap commands and pad drive
  input wire logic tie_i,
  input wire logic pad_n_i,
  input wire logic pad_oe_i,
  input wire logic pullup_i,
  // Resolved pin level
  output logic pin_n_o
);
  ////////////////////////////////////////////////////////////////////
  // Pad drive beats strap, strap beats pull-up
  assign pin_n_o = pad_oe_i ? pad_n_i : tie_i ? 1'b0
    : pullup_i ? 1'b1 : 1'bz;
endmodule

// ### tb/pin_float_test_mode_control_tb.sv
// Purpose: Self-checking bench for the pin float test mode block
// Assumes: Inputs change on the falling clock edge
// Notes: Straps model the board; core drive comes from the bench
`timescale 1ns/1ps
module pin_float_test_mode_control_tb;
  import pftm_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, res_n = 1'b0, hold = 1'b0;
  logic xtal = 1'b0, s_u = 1'b0, s_l = 1'b0;
  logic cu_n = 1'b1, cl_n = 1'b1;
  logic u_n, l_n, ucs_n, ucs_oe, lcs_n, lcs_oe, pu, x_o, mode;
  pftm_ad_t ad = 16'ha55a;
  pftm_misc_t misc = 32'hc3c3_ffff;
  pftm_ad_t pad_ad;
  pftm_misc_t pad_misc;
  int n_errors = 0, num_checks = 0;
  ////////////////////////////////////////////////////////////////////
  // 100 MHz clock
  always #5 clk_i = ~clk_i;
  pftm_ctrl uut (.clk_i, .rst_i, .reset_input_n_i(res_n),
    .upper_memory_select_n_i(u_n), .lower_memory_select_n_i(l_n),
    .hold_ack_i(hold), .core_ad_i(ad), .core_misc_i(misc),
    .core_ucs_n_i(cu_n), .core_lcs_n_i(cl_n), .crystal_output_i(xtal),
    .pad_ad_o(pad_ad), .pad_misc_o(pad_misc), .pad_ucs_n_o(ucs_n),
    .pad_ucs_oe_o(ucs_oe), .pad_lcs_n_o(lcs_n), .pad_lcs_oe_o(lcs_oe),
    .select_pullup_en_o(pu), .crystal_output_o(x_o),
    .pin_float_test_mode_o(mode));
  pftm_strap u_su (.tie_i(s_u), .pad_n_i(ucs_n), .pad_oe_i(ucs_oe),
    .pullup_i(pu), .pin_n_o(u_n));
  pftm_strap u_sl (.tie_i(s_l), .pad_n_i(lcs_n), .pad_oe_i(lcs_oe),
    .pullup_i(pu), .pin_n_o(l_n));
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Reset pin pulse with straps held past the synchroniser
  task boot(input logic u, input logic l);
    s_u = u;
    s_l = l;
    res_n = 1'b0;
    wt(5);
    res_n = 1'b1;
    // Two edges on, the rise has crossed the synchroniser but the registered mode output has not moved yet
    wt(2);
    chk(mode, 1'b0);
    wt(2);
    s_u = 1'b0;
    s_l = 1'b0;
    wt(3);
  endtask
  task t_run;
    boot(1'b0, 1'b0);
    chk(mode, 1'b0);
    chk(pad_ad.oe, 8'h5a);
    chk(pad_ad.dout, 8'ha5);
    chk(pad_misc.oe, 16'hffff);
    chk(pad_misc.dout, 16'hc3c3);
    chk({ucs_oe, lcs_oe}, 2'h3);
    chk(pu, 1'b1);
    // Selects driven low in run are not a mode request
    cu_n = 1'b0;
    cl_n = 1'b0;
    wt(3);
    chk({ucs_n, lcs_n}, 2'h0);
    chk(mode, 1'b0);
    cu_n = 1'b1;
    cl_n = 1'b1;
    hold = 1'b1;
    wt(3);
    chk(pad_ad.oe, 8'h00);
    chk({ucs_oe, lcs_oe}, 2'h3);
    hold = 1'b0;
    wt(3);
    chk(pad_ad.oe, 8'h5a);
    res_n = 1'b0;
    wt(5);
    chk(pad_ad.oe, 8'h00);
    chk({ucs_oe, lcs_oe}, 2'h0);
    res_n = 1'b1;
    wt(6);
    chk(pad_ad.oe, 8'h5a);
    $display("test run done");
  endtask
  task t_one;
    boot(1'b1, 1'b0);
    chk(mode, 1'b0);
    chk(pad_ad.oe, 8'h5a);
    boot(1'b0, 1'b1);
    chk(mode, 1'b0);
    chk(pad_misc.oe, 16'hffff);
    $display("test one strap done");
  endtask
  task t_float;
    boot(1'b1, 1'b1);
    chk(mode, 1'b1);
    chk({pad_ad.oe, ucs_oe, lcs_oe}, 10'h000);
    chk(pad_misc.oe, 16'h0000);
    xtal = 1'b1;
    wt(2);
    chk(x_o, 1'b1);
    xtal = 1'b0;
    wt(2);
    chk(x_o, 1'b0);
    wt(20);
    chk(mode, 1'b1);
    chk(pad_ad.oe, 8'h00);
    res_n = 1'b0;
    wt(5);
    chk(mode, 1'b0);
    chk(pad_ad.oe, 8'h00);
    res_n = 1'b1;
    wt(6);
    chk(mode, 1'b0);
    chk(pad_ad.oe, 8'h5a);
    $display("test float done");
  endtask
  task close_out;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Watchdog: the tests take well under 2 us
  initial begin
    #20000;
    n_errors++;
    close_out;
  end
  initial begin
    wt(8);
    rst_i = 1'b0;
    t_run;
    t_one;
    t_float;
    close_out;
  end
endmodule
